/* mss_pkg.sv */
// Constants and state type shared by the memory size select register block.
`default_nettype none
package mss_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] MAIN_OFFSET = 16'hfff0;
  localparam logic [15:0] EXP_OFFSET = 16'hfff4;
  localparam logic [7:0] MAIN_RESET = 8'hcf;
  localparam logic [7:0] EXP_RESET = 8'h0c;
  localparam logic [7:0] MAIN_WRITE_MASK = 8'hef;
  localparam logic [7:0] EXP_WRITE_MASK = 8'h1f;
  localparam int FAST_MSB = 7;
  localparam int FAST_LSB = 5;
  localparam int PROG_MSB = 3;
  localparam int PROG_LSB = 0;
  localparam int EXPF_MSB = 4;
  localparam int EXPF_LSB = 0;
  localparam logic [2:0] FAST_1K_CODE = 3'h6;
  localparam logic [3:0] PROG_16K_CODE = 4'h4;
  localparam logic [4:0] EXP_2K_CODE = 5'h08;
  localparam logic [15:0] FAST_RAM_BYTES = 16'h0400;
  localparam logic [7:0] PROG_STORE_KBYTES = 8'h10;
  localparam logic [15:0] EXP_RAM_BYTES = 16'h0800;
  localparam logic [15:0] NO_BYTES = 16'h0000;
  localparam logic [7:0] NO_KBYTES = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  typedef struct packed {
    logic [7:0] main_sel;
    logic [7:0] exp_sel;
    logic [7:0] rdata;
    logic fast_ok;
    logic prog_ok;
    logic exp_ok;
    logic [15:0] fast_bytes;
    logic [7:0] prog_kbytes;
    logic [15:0] exp_bytes;
  } mss_state_t;
endpackage
`default_nettype wire

/* mss_size_if.sv */
// Interface between the register file and its write and decode unit.
`default_nettype none
interface mss_size_if;
  logic [7:0] cur_main;
  logic [7:0] cur_exp;
  logic wr_main;
  logic wr_exp;
  logic [7:0] wdata;
  logic [7:0] next_main;
  logic [7:0] next_exp;
  logic fast_ok;
  logic prog_ok;
  logic exp_ok;
  logic [15:0] fast_bytes;
  logic [7:0] prog_kbytes;
  logic [15:0] exp_bytes;
  modport regs (output cur_main, cur_exp, wr_main, wr_exp, wdata,
    input next_main, next_exp, fast_ok, prog_ok, exp_ok, fast_bytes, prog_kbytes, exp_bytes);
  modport unit (input cur_main, cur_exp, wr_main, wr_exp, wdata,
    output next_main, next_exp, fast_ok, prog_ok, exp_ok, fast_bytes, prog_kbytes, exp_bytes);
endinterface
`default_nettype wire

/* mss_size_decode.sv */
// Write masking and capacity decode for the two size select registers.
`default_nettype none
module mss_size_decode (
  mss_size_if.unit sz
);
  import mss_pkg::*;

  always_comb
  begin
    // A write always replaces the whole byte; the fixed-zero bits are forced here.
    sz.next_main = sz.wr_main ? (sz.wdata & MAIN_WRITE_MASK) : sz.cur_main;
    sz.next_exp = sz.wr_exp ? (sz.wdata & EXP_WRITE_MASK) : sz.cur_exp;
    // Decoding the next value lets a new selection act the cycle after the write.
    sz.fast_ok = (sz.next_main[FAST_MSB:FAST_LSB] == FAST_1K_CODE);
    sz.prog_ok = (sz.next_main[PROG_MSB:PROG_LSB] == PROG_16K_CODE);
    sz.exp_ok = (sz.next_exp[EXPF_MSB:EXPF_LSB] == EXP_2K_CODE);
    // Prohibited codes map no memory at all rather than guessing a size.
    sz.fast_bytes = sz.fast_ok ? FAST_RAM_BYTES : NO_BYTES;
    sz.prog_kbytes = sz.prog_ok ? PROG_STORE_KBYTES : NO_KBYTES;
    sz.exp_bytes = sz.exp_ok ? EXP_RAM_BYTES : NO_BYTES;
  end
endmodule
`default_nettype wire

/* mss_regs.sv */
// Memory size select register bank on the processor memory bus.
// Function
// - Reset loads the main memory size select register with CF hex.
// - The main register is written only as a whole byte by a memory write.
// - Bits 7 to 5 select fast RAM, only the 1024-byte code is valid, and bit 4 stays zero.
// - Bits 3 to 0 select program store size, 0100 gives 16 KB, all else is prohibited.
// - Reset loads the expansion RAM size select register with 0C hex.
// - The expansion register is written only as a whole byte by a memory write.
// - Bits 4 to 0 select expansion RAM, 01000 gives 2048 bytes, and bits 7 to 5 stay zero.
`default_nettype none
module mss_regs (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [mss_pkg::ADDR_W-1:0] addr_in,
  input wire logic wr_in,
  input wire logic [mss_pkg::DATA_W-1:0] wdata_in,
  input wire logic rd_in,
  output logic [mss_pkg::DATA_W-1:0] rdata_out,
  output logic [mss_pkg::DATA_W-1:0] main_memory_size_select_out,
  output logic [mss_pkg::DATA_W-1:0] expansion_ram_size_select_out,
  output logic fast_ram_ok_out,
  output logic [15:0] fast_ram_bytes_out,
  output logic program_store_ok_out,
  output logic [7:0] program_store_kbytes_out,
  output logic expansion_ok_out,
  output logic [15:0] expansion_bytes_out
);
  import mss_pkg::*;

  mss_state_t state;
  mss_state_t next_state;
  mss_size_if sz ();

  ////////////////////////////////////////////////////////////////////////////////
  mss_size_decode u_decode (
    .sz(sz)
  );

  assign sz.cur_main = state.main_sel;
  assign sz.cur_exp = state.exp_sel;
  // The bus has no bit-level write path, so only full byte stores reach the registers.
  assign sz.wr_main = ce_in && wr_in && (addr_in == MAIN_OFFSET);
  assign sz.wr_exp = ce_in && wr_in && (addr_in == EXP_OFFSET);
  assign sz.wdata = wdata_in;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state = state;
    if (ce_in)
    begin
      next_state.main_sel = sz.next_main;
      next_state.exp_sel = sz.next_exp;
      next_state.fast_ok = sz.fast_ok;
      next_state.prog_ok = sz.prog_ok;
      next_state.exp_ok = sz.exp_ok;
      next_state.fast_bytes = sz.fast_bytes;
      next_state.prog_kbytes = sz.prog_kbytes;
      next_state.exp_bytes = sz.exp_bytes;
      // Unmapped or idle reads return zero while ce_in is high; with ce_in low the last byte is held.
      next_state.rdata = READ_IDLE;
      if (rd_in && (addr_in == MAIN_OFFSET))
      begin
        next_state.rdata = state.main_sel;
      end
      else if (rd_in && (addr_in == EXP_OFFSET))
      begin
        next_state.rdata = state.exp_sel;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state.main_sel <= MAIN_RESET;
      state.exp_sel <= EXP_RESET;
      state.rdata <= READ_IDLE;
      // The reset code already selects valid fast RAM; program store and expansion RAM
      // stay unmapped until software writes its settings.
      state.fast_ok <= 1'b1;
      state.prog_ok <= 1'b0;
      state.exp_ok <= 1'b0;
      state.fast_bytes <= FAST_RAM_BYTES;
      state.prog_kbytes <= NO_KBYTES;
      state.exp_bytes <= NO_BYTES;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rdata_out = state.rdata;
  assign main_memory_size_select_out = state.main_sel;
  assign expansion_ram_size_select_out = state.exp_sel;
  assign fast_ram_ok_out = state.fast_ok;
  assign fast_ram_bytes_out = state.fast_bytes;
  assign program_store_ok_out = state.prog_ok;
  assign program_store_kbytes_out = state.prog_kbytes;
  assign expansion_ok_out = state.exp_ok;
  assign expansion_bytes_out = state.exp_bytes;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_main_write;
    ce_in && wr_in && (addr_in == MAIN_OFFSET);
  endsequence

  sequence s_exp_write;
    ce_in && wr_in && (addr_in == EXP_OFFSET);
  endsequence

  sequence s_main_read;
    ce_in && rd_in && (addr_in == MAIN_OFFSET) && !wr_in;
  endsequence

  sequence s_exp_read;
    ce_in && rd_in && (addr_in == EXP_OFFSET) && !wr_in;
  endsequence

  property p_main_reset;
    $fell(rst_in) |-> (state.main_sel == MAIN_RESET) && !state.prog_ok;
  endproperty
  a_main_reset: assert property (p_main_reset) else $error("main reset value wrong");

  property p_exp_reset;
    $fell(rst_in) |-> (state.exp_sel == EXP_RESET) && !state.exp_ok;
  endproperty
  a_exp_reset: assert property (p_exp_reset) else $error("expansion reset value wrong");

  property p_main_write;
    logic [7:0] d;
    (s_main_write, d = wdata_in) |=> (state.main_sel == (d & MAIN_WRITE_MASK));
  endproperty
  a_main_write: assert property (p_main_write) else $error("main byte write not stored");

  property p_exp_write;
    logic [7:0] d;
    (s_exp_write, d = wdata_in) |=> (state.exp_sel == (d & EXP_WRITE_MASK));
  endproperty
  a_exp_write: assert property (p_exp_write) else $error("expansion write not stored");

  property p_main_bit4_zero;
    state.main_sel[4] == 1'b0;
  endproperty
  a_main_bit4_zero: assert property (p_main_bit4_zero) else $error("main bit 4 set");

  property p_exp_high_zero;
    state.exp_sel[7:5] == 3'h0;
  endproperty
  a_exp_high_zero: assert property (p_exp_high_zero) else $error("exp high bits set");

  property p_fast_decode;
    fast_ram_ok_out == (main_memory_size_select_out[FAST_MSB:FAST_LSB] == FAST_1K_CODE);
  endproperty
  a_fast_decode: assert property (p_fast_decode) else $error("fast RAM decode wrong");

  property p_prog_decode;
    program_store_ok_out == (main_memory_size_select_out[PROG_MSB:PROG_LSB] == PROG_16K_CODE);
  endproperty
  a_prog_decode: assert property (p_prog_decode) else $error("program decode wrong");

  property p_exp_decode;
    expansion_ok_out == (expansion_ram_size_select_out[EXPF_MSB:EXPF_LSB] == EXP_2K_CODE);
  endproperty
  a_exp_decode: assert property (p_exp_decode) else $error("expansion decode wrong");

  property p_main_readback;
    s_main_read |=> (rdata_out == $past(state.main_sel));
  endproperty
  a_main_readback: assert property (p_main_readback) else $error("main read value wrong");

  property p_write_takes_effect;
    s_main_write ##0 (wdata_in == 8'hc4) |=> fast_ram_ok_out && program_store_ok_out;
  endproperty
  a_write_takes_effect: assert property (p_write_takes_effect) else $error("C4 unmapped");

  property p_exp_readback;
    s_exp_read |=> (rdata_out == $past(state.exp_sel));
  endproperty
  a_exp_readback: assert property (p_exp_readback) else $error("expansion read wrong");

  // While ce_in is high, an unmapped or absent read must not leave an old byte on the bus.
  property p_read_idle;
    ce_in && !(rd_in && ((addr_in == MAIN_OFFSET) || (addr_in == EXP_OFFSET))) |=>
      (rdata_out == READ_IDLE);
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("idle read not zero");

  property p_main_untouched;
    ce_in && !(wr_in && (addr_in == MAIN_OFFSET)) |=> $stable(state.main_sel);
  endproperty
  a_main_untouched: assert property (p_main_untouched) else $error("main changed");

  property p_exp_untouched;
    ce_in && !(wr_in && (addr_in == EXP_OFFSET)) |=> $stable(state.exp_sel);
  endproperty
  a_exp_untouched: assert property (p_exp_untouched) else $error("exp changed");

  property p_exp_effect;
    s_exp_write ##0 (wdata_in == 8'h08) |=>
      expansion_ok_out && (expansion_bytes_out == EXP_RAM_BYTES);
  endproperty
  a_exp_effect: assert property (p_exp_effect) else $error("08 unmapped");

  property p_map_bytes;
    (fast_ram_bytes_out == (fast_ram_ok_out ? FAST_RAM_BYTES : NO_BYTES)) &&
      (expansion_bytes_out == (expansion_ok_out ? EXP_RAM_BYTES : NO_BYTES));
  endproperty
  a_map_bytes: assert property (p_map_bytes) else $error("capacity wrong");

  property p_prog_kbytes;
    program_store_kbytes_out == (program_store_ok_out ? PROG_STORE_KBYTES : NO_KBYTES);
  endproperty
  a_prog_kbytes: assert property (p_prog_kbytes) else $error("program size wrong");

  property p_reset_fast;
    $fell(rst_in) |-> fast_ram_ok_out && (fast_ram_bytes_out == FAST_RAM_BYTES);
  endproperty
  a_reset_fast: assert property (p_reset_fast) else $error("reset map wrong");

  property p_freeze;
    !ce_in |=> $stable(state);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
endmodule
`default_nettype wire

/* mss_regs_tb.sv */
// Self-checking bench for the memory size select register bank.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mss_pkg::*;
  typedef struct packed {
    logic [7:0] rd;
    logic [7:0] m;
    logic [7:0] x;
  } mss_exp_t;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b0;
  logic [15:0] addr_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] wdata_in = 8'h00;
  logic [7:0] rdata, m_sel, x_sel, p_kb, mm, mx, mr;
  logic f_ok, p_ok, x_ok;
  logic [15:0] f_bytes, x_bytes;
  logic [31:0] r;
  mss_exp_t q[$];
  mss_exp_t e;
  int n_errors = 0;
  int compares = 0;
  integer seed = 640;
  mss_regs mss_regs_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .addr_in(addr_in), .wr_in(wr_in), .wdata_in(wdata_in), .rd_in(rd_in),
    .rdata_out(rdata), .main_memory_size_select_out(m_sel),
    .expansion_ram_size_select_out(x_sel), .fast_ram_ok_out(f_ok),
    .fast_ram_bytes_out(f_bytes), .program_store_ok_out(p_ok),
    .program_store_kbytes_out(p_kb), .expansion_ok_out(x_ok), .expansion_bytes_out(x_bytes));
  always #4 core_clk_in = ~core_clk_in;
  //////////////////////////////////////////////////////////////////////////////
  task check(input string name, input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, want, seen);
    end
  endtask
  task print_verdict;
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Results land one edge after the access, so the oldest note is due each falling edge.
  always @(negedge core_clk_in)
    if (q.size() > 0)
    begin
      e = q.pop_front();
      check("rdata", 16'(rdata), 16'(e.rd));
      check("main", 16'(m_sel), 16'(e.m));
      check("exp", 16'(x_sel), 16'(e.x));
      check("fast_ok", 16'(f_ok), 16'(e.m[7:5] == 3'h6));
      check("fast_bytes", f_bytes, (e.m[7:5] == 3'h6) ? 16'h0400 : 16'h0000);
      check("prog_ok", 16'(p_ok), 16'(e.m[3:0] == 4'h4));
      check("prog_kb", 16'(p_kb), (e.m[3:0] == 4'h4) ? 16'h0010 : 16'h0000);
      check("exp_ok", 16'(x_ok), 16'(e.x[4:0] == 5'h08));
      check("exp_bytes", x_bytes, (e.x[4:0] == 5'h08) ? 16'h0800 : 16'h0000);
    end
  //////////////////////////////////////////////////////////////////////////////
  task acc(input logic c, input logic w, input logic rr, input logic [15:0] a,
    input logic [7:0] d);
    ce_in <= c;
    wr_in <= w;
    rd_in <= rr;
    addr_in <= a;
    wdata_in <= d;
    if (c)
    begin
      mr = (rr && a == MAIN_OFFSET) ? mm : (rr && a == EXP_OFFSET) ? mx : 8'h00;
      if (w && a == MAIN_OFFSET)
        mm = d & 8'hef;
      if (w && a == EXP_OFFSET)
        mx = d & 8'h1f;
    end
    @(posedge core_clk_in);
    q.push_back('{mr, mm, mx});
  endtask
  // The extra edge first lets the last pending note be checked before reset hits.
  task do_reset(input int n);
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    ce_in <= 1'b0;
    mm = 8'hcf;
    mx = 8'h0c;
    mr = 8'h00;
    repeat (n) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  initial
  begin
    do_reset(10);
    acc(1'b0, 1'b0, 1'b0, MAIN_OFFSET, 8'h00);
    acc(1'b1, 1'b0, 1'b1, MAIN_OFFSET, 8'h00);
    acc(1'b1, 1'b0, 1'b1, EXP_OFFSET, 8'h00);
    acc(1'b1, 1'b1, 1'b0, MAIN_OFFSET, 8'hc4);
    acc(1'b1, 1'b1, 1'b1, EXP_OFFSET, 8'h08);
    acc(1'b1, 1'b0, 1'b1, EXP_OFFSET, 8'h00);
    acc(1'b1, 1'b1, 1'b1, MAIN_OFFSET, 8'hff);
    acc(1'b1, 1'b1, 1'b1, EXP_OFFSET, 8'hff);
    acc(1'b1, 1'b1, 1'b1, 16'hfff1, 8'h55);
    acc(1'b0, 1'b1, 1'b1, MAIN_OFFSET, 8'hc4);
    acc(1'b1, 1'b0, 1'b0, MAIN_OFFSET, 8'h00);
    for (int i = 0; i < 32; i++)
    begin
      acc(1'b1, 1'b1, 1'b0, MAIN_OFFSET, {i[2:0], 1'b1, i[3:0]});
      acc(1'b1, 1'b1, 1'b1, EXP_OFFSET, {i[2:0], i[4:0]});
    end
    for (int i = 0; i < 80; i++)
    begin
      r = $random(seed);
      acc(r[0] | r[1], r[2], r[3], r[5] ? MAIN_OFFSET : (r[6] ? EXP_OFFSET :
        {12'hfff, r[11:8]}), r[23:16]);
    end
    do_reset(2);
    acc(1'b1, 1'b0, 1'b1, MAIN_OFFSET, 8'h00);
    acc(1'b1, 1'b1, 1'b0, MAIN_OFFSET, 8'hc4);
    acc(1'b1, 1'b1, 1'b0, EXP_OFFSET, 8'h08);
    acc(1'b0, 1'b0, 1'b0, EXP_OFFSET, 8'h00);
    for (int i = 0; i < 4 && q.size() > 0; i++)
      @(posedge core_clk_in);
    check("pending", 16'(q.size()), 16'h0000);
    print_verdict;
  end
endmodule
`default_nettype wire
